// ===== pkg/pgc_pkg.sv
// package for the ptp general setup register bank
package pgc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] PGC_ADDR_CMD    = 12'h100;
  localparam logic [11:0] PGC_ADDR_SETUP  = 12'h104;
  localparam logic [11:0] PGC_ADDR_STATUS = 12'h108;
  localparam logic [11:0] PGC_ADDR_MASK   = 12'h10c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PGC_BIT_MAIN_EN   = 2;
  localparam int PGC_BIT_TS_ON     = 16;
  localparam int PGC_BIT_PCLR_EN   = 15;
  localparam int PGC_SEL_LSB       = 12;
  localparam int PGC_SEL_W         = 3;
  localparam int PGC_NUM_PINS      = 3;
  localparam int PGC_BIT_TMRB      = 1;
  localparam int PGC_BIT_PIN_EDGE  = 0;
  localparam int PGC_IRQ_W         = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic       PGC_RST_TS_ON   = 1'b1;
  localparam logic       PGC_RST_PCLR_EN = 1'b0;
  localparam logic [2:0] PGC_RST_SEL     = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PGC_CLK_NS      = 40;
  localparam int PGC_MIN_ACT_NS  = 40;
  // active level must persist longer than the minimum: strictly greater
  localparam int PGC_MIN_ACT_CYC = (PGC_MIN_ACT_NS / PGC_CLK_NS) + 1;
  localparam int PGC_CNT_W       = 4;

  typedef struct packed {
    logic       ts_on;
    logic       pclr_en;
    logic [2:0] sel;
  } pgc_setup_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } pgc_req_t;

endpackage : pgc_pkg

// ===== hw/pgc_edge_det.sv
// qualifies one active edge on the selected pin
`timescale 1ns/1ps
`default_nettype none
module pgc_edge_det
  import pgc_pkg::*;
#(
  parameter int MIN_CYC = PGC_MIN_ACT_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin_level,
  input  wire logic active_high,
  output logic      edge_pulse
);

  logic [2:0]           sync_reg, sync_next;
  logic                 state_reg, state_next;
  logic [PGC_CNT_W-1:0] cnt_reg, cnt_next;
  logic                 pulse_reg, pulse_next;
  logic                 act;

  // ----------------------------------------------------------------
  // sync and filter
  // ----------------------------------------------------------------
  always_comb begin
    sync_next  = {sync_reg[1:0], pin_level};
    act        = (sync_reg[2] == active_high) && (sync_reg[1] == active_high);
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pulse_next = 1'b0;
    if (sync_reg[2] != sync_reg[1]) begin
      cnt_next = cnt_reg;
    end else if (!act) begin
      cnt_next   = '0;
      state_next = 1'b0;
    end else if (!state_reg) begin
      // edge only after the level has stood past the minimum
      if (cnt_reg >= PGC_CNT_W'(MIN_CYC)) begin
        state_next = 1'b1;
        pulse_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + PGC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_reg  <= 3'h0;
      state_reg <= 1'b1;
      cnt_reg   <= '0;
      pulse_reg <= 1'b0;
    end else begin
      sync_reg  <= sync_next;
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign edge_pulse = pulse_reg;

  a_edge_once: assert property (@(posedge clk_sys) disable iff (rst)
    edge_pulse |=> !edge_pulse) else $error("edge pulse longer than one cycle");

endmodule : pgc_edge_det
`default_nettype wire

// ===== hw/pgc_top.sv
// ptp general setup register bank with pin-driven timer b flag clear
//
// Contract
// - bit 16 gates stamping, reset one, needs main enable
// - bit 15 lets pin edge clear timer b flag
// - bits 14:12 pick clearing pin, reset zero
// - selector addresses only three supported pins
// - pin active level comes from pin polarity
// - edge needs active level longer than 40 ns
// - writing one enables unit, read returns state
`timescale 1ns/1ps
`default_nettype none
module pgc_top
  import pgc_pkg::*;
#(
  parameter int NUM_PINS = PGC_NUM_PINS
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_PINS-1:0] gpio_in,
  input  wire logic [NUM_PINS-1:0] pin_polarity,
  input  wire logic                tmrb_event,
  input  wire logic                main_disable,
  output logic                     ptp_enable,
  output logic                     timestamp_capture_on,
  output logic                     irq
);

  pgc_setup_t            setup_reg, setup_next;
  logic                  main_en_reg, main_en_next;
  logic [PGC_IRQ_W-1:0]  ptp_irq_status_reg, ptp_irq_status_next;
  logic [PGC_IRQ_W-1:0]  mask_reg, mask_next;
  logic [31:0]           prdata_reg, prdata_next;
  logic                  pready_reg, pready_next;
  logic                  pslverr_reg, pslverr_next;
  logic                  ts_out_reg, ts_out_next;
  logic                  irq_reg, irq_next;
  logic                  sel_pin, sel_pol, sel_ok, pin_edge;
  logic                  acc, wr;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == PGC_ADDR_CMD) || (a == PGC_ADDR_SETUP) ||
              (a == PGC_ADDR_STATUS) || (a == PGC_ADDR_MASK);
  endfunction : addr_ok

  // ----------------------------------------------------------------
  // pin selection
  // ----------------------------------------------------------------
  always_comb begin
    // codes past the supported pins select nothing
    sel_ok  = (32'(setup_reg.sel) < NUM_PINS);
    sel_pin = 1'b0;
    sel_pol = 1'b1;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (32'(setup_reg.sel) == i) begin
        sel_pin = gpio_in[i];
        sel_pol = pin_polarity[i];
      end
    end
  end

  // pin direction is software's job; the pin is only sampled here
  pgc_edge_det u_edge (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .pin_level   (sel_pin),
    .active_high (sel_pol),
    .edge_pulse  (pin_edge)
  );

  // ----------------------------------------------------------------
  // apb slave and registers
  // ----------------------------------------------------------------
  assign acc = psel && penable && !pready_reg;
  assign wr  = acc && pwrite && addr_ok(paddr);

  always_comb begin
    setup_next          = setup_reg;
    main_en_next        = main_en_reg;
    ptp_irq_status_next = ptp_irq_status_reg;
    mask_next           = mask_reg;
    prdata_next         = prdata_reg;
    pready_next         = acc;
    pslverr_next        = acc && !addr_ok(paddr);

    if (main_disable) begin
      main_en_next = 1'b0;
    end
    if (wr && paddr == PGC_ADDR_CMD && pwdata[PGC_BIT_MAIN_EN]) begin
      main_en_next = 1'b1;
    end
    if (wr && paddr == PGC_ADDR_SETUP) begin
      // software must not alter bit 16 while enabled; write stored as given
      setup_next.ts_on   = pwdata[PGC_BIT_TS_ON];
      setup_next.pclr_en = pwdata[PGC_BIT_PCLR_EN];
      setup_next.sel     = pwdata[PGC_SEL_LSB +: PGC_SEL_W];
    end
    if (wr && paddr == PGC_ADDR_MASK) begin
      mask_next = pwdata[PGC_IRQ_W-1:0];
    end
    if (wr && paddr == PGC_ADDR_STATUS) begin
      ptp_irq_status_next = ptp_irq_status_next & ~pwdata[PGC_IRQ_W-1:0];
    end
    // pin edge clears timer b flag, but a new compare event wins
    if (setup_reg.pclr_en && sel_ok && pin_edge) begin
      ptp_irq_status_next[PGC_BIT_TMRB] = 1'b0;
    end
    if (pin_edge && sel_ok) begin
      ptp_irq_status_next[PGC_BIT_PIN_EDGE] = 1'b1;
    end
    if (tmrb_event) begin
      ptp_irq_status_next[PGC_BIT_TMRB] = 1'b1;
    end

    if (acc && !pwrite) begin
      prdata_next = 32'h0;
      // reserved bits read zero
      unique case (paddr)
        PGC_ADDR_CMD:    prdata_next[PGC_BIT_MAIN_EN] = main_en_reg;
        PGC_ADDR_SETUP: begin
          prdata_next[PGC_BIT_TS_ON]              = setup_reg.ts_on;
          prdata_next[PGC_BIT_PCLR_EN]            = setup_reg.pclr_en;
          prdata_next[PGC_SEL_LSB +: PGC_SEL_W]   = setup_reg.sel;
        end
        PGC_ADDR_STATUS: prdata_next[PGC_IRQ_W-1:0] = ptp_irq_status_reg;
        PGC_ADDR_MASK:   prdata_next[PGC_IRQ_W-1:0] = mask_reg;
        default:         prdata_next = 32'h0;
      endcase
    end

    // stamping only while both enables stand
    ts_out_next = setup_next.ts_on && main_en_next;
    irq_next    = |(ptp_irq_status_next & mask_next);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      setup_reg          <= '{ts_on: PGC_RST_TS_ON, pclr_en: PGC_RST_PCLR_EN,
                              sel: PGC_RST_SEL};
      main_en_reg        <= 1'b0;
      ptp_irq_status_reg <= '0;
      mask_reg           <= '0;
      prdata_reg         <= 32'h0;
      pready_reg         <= 1'b0;
      pslverr_reg        <= 1'b0;
      ts_out_reg         <= 1'b0;
      irq_reg            <= 1'b0;
    end else begin
      setup_reg          <= setup_next;
      main_en_reg        <= main_en_next;
      ptp_irq_status_reg <= ptp_irq_status_next;
      mask_reg           <= mask_next;
      prdata_reg         <= prdata_next;
      pready_reg         <= pready_next;
      pslverr_reg        <= pslverr_next;
      ts_out_reg         <= ts_out_next;
      irq_reg            <= irq_next;
    end
  end

  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign ptp_enable           = main_en_reg;
  assign timestamp_capture_on = ts_out_reg;
  assign irq                  = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ts_gate: assert property (@(posedge clk_sys) disable iff (rst)
    timestamp_capture_on |-> (setup_reg.ts_on && main_en_reg))
    else $error("stamping on without both enables");
  a_ts_follow: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_reg.ts_on && main_en_reg) |-> timestamp_capture_on)
    else $error("stamping off with both enables");
  a_pin_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (setup_reg.pclr_en && sel_ok && pin_edge && !tmrb_event) |=>
      !ptp_irq_status_reg[PGC_BIT_TMRB]) else $error("pin edge left flag set");
  a_no_clear_off: assert property (@(posedge clk_sys) disable iff (rst)
    (!setup_reg.pclr_en && ptp_irq_status_reg[PGC_BIT_TMRB] && !wr) |=>
      ptp_irq_status_reg[PGC_BIT_TMRB]) else $error("flag cleared while disabled");
  a_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
    tmrb_event |=> ptp_irq_status_reg[PGC_BIT_TMRB]) else $error("event lost");
  a_sel_write: assert property (@(posedge clk_sys) disable iff (rst)
    (wr && paddr == PGC_ADDR_SETUP) |=>
      setup_reg.sel == $past(pwdata[PGC_SEL_LSB +: PGC_SEL_W]))
    else $error("selector not stored");
  // an unsupported code must never let any pin edge reach the status bits
  a_bad_sel: assert property (@(posedge clk_sys) disable iff (rst)
    (32'(setup_reg.sel) >= NUM_PINS && !wr) |=>
      ptp_irq_status_reg[PGC_BIT_PIN_EDGE] == $past(ptp_irq_status_reg[PGC_BIT_PIN_EDGE]))
    else $error("unsupported pin code took an edge");
  a_main_en: assert property (@(posedge clk_sys) disable iff (rst)
    (wr && paddr == PGC_ADDR_CMD && pwdata[PGC_BIT_MAIN_EN]) |=> ptp_enable)
    else $error("enable write ignored");
  a_resv_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (pready && $past(paddr) == PGC_ADDR_SETUP) |-> prdata[31:17] == 15'h0)
    else $error("reserved bits nonzero");
  a_ready_one: assert property (@(posedge clk_sys) disable iff (rst)
    pready |=> !pready) else $error("pready held"); 

  c_pin_clear: cover property (@(posedge clk_sys) disable iff (rst)
    setup_reg.pclr_en && pin_edge && ptp_irq_status_reg[PGC_BIT_TMRB]);
  c_irq: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
  c_enable: cover property (@(posedge clk_sys) disable iff (rst) $rose(ptp_enable));
  c_err: cover property (@(posedge clk_sys) disable iff (rst) pslverr);

endmodule : pgc_top
`default_nettype wire

// ===== sim/test_pgc_top.sv
// self-checking bench for the ptp general setup register bank
`timescale 1ns/1ps
`default_nettype none
module test_pgc_top
  import pgc_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk_sys;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  gpio_in;
  logic [2:0]  pin_polarity;
  logic        tmrb_event;
  logic        main_disable;
  logic        ptp_enable;
  logic        timestamp_capture_on;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          n_checks;

  // pin 1 is active low so both polarities get exercised
  localparam logic [2:0] POL = 3'b101;

  // pin case table: selector, pulsed pin, enable, active cycles, flag cleared
  logic [2:0] c_sel [7] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h3, 3'h1, 3'h2};
  int         c_pin [7] = '{0, 1, 2, 0, 0, 0, 2};
  logic       c_en  [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  int         c_cyc [7] = '{4, 4, 4, 4, 4, 4, 1};
  logic       c_clr [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  // edge seen on a supported selected pin held long enough, whatever the clear enable
  logic       c_edg [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  pgc_top dut (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .gpio_in              (gpio_in),
    .pin_polarity         (pin_polarity),
    .tmrb_event           (tmrb_event),
    .main_disable         (main_disable),
    .ptp_enable           (ptp_enable),
    .timestamp_capture_on (timestamp_capture_on),
    .irq                  (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // request stands until pready is seen high at a rising edge; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    // one wait state: pready is seen at the second edge of the access phase
    chk("apb access edges", n, 32'h2);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pin_case(input int k);
    @(posedge clk_sys) tmrb_event <= 1'b1;
    @(posedge clk_sys) tmrb_event <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("irq armed", {31'h0, irq}, 32'h1);
    apb(1'b1, PGC_ADDR_SETUP, {15'h0, 1'b1, c_en[k], c_sel[k], 12'h0});
    // pins are only ever driven by the bench, as inputs of the block
    @(posedge clk_sys) gpio_in[c_pin[k]] <= POL[c_pin[k]];
    repeat (c_cyc[k]) @(posedge clk_sys);
    gpio_in[c_pin[k]] <= ~POL[c_pin[k]];
    repeat (12) @(posedge clk_sys);
    apb(1'b0, PGC_ADDR_STATUS, 32'h0);
    chk("timer b flag", {31'h0, rd[PGC_BIT_TMRB]}, {31'h0, ~c_clr[k]});
    chk("pin edge flag", {31'h0, rd[PGC_BIT_PIN_EDGE]}, {31'h0, c_edg[k]});
    chk("irq", {31'h0, irq}, {31'h0, ~c_clr[k]});
    // write one clears only the pin edge bit, the timer b flag stays as it was
    apb(1'b1, PGC_ADDR_STATUS, 32'h0000_0001);
    apb(1'b0, PGC_ADDR_STATUS, 32'h0);
    chk("status after clear", rd, {30'h0, ~c_clr[k], 1'b0});
  endtask : pin_case

  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs about 340 cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pin_polarity = POL;
    gpio_in = ~POL;
    tmrb_event = 1'b0;
    main_disable = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;

    apb(1'b0, PGC_ADDR_SETUP, 32'h0);
    chk("setup reset", rd, 32'h0001_0000);
    chk("capture reset", {31'h0, timestamp_capture_on}, 32'h0);
    $display("test reset values done");

    apb(1'b1, PGC_ADDR_SETUP, 32'hffff_ffff);
    apb(1'b0, PGC_ADDR_SETUP, 32'h0);
    chk("setup all ones", rd, 32'h0001_f000);
    chk("capture main off", {31'h0, timestamp_capture_on}, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped read", rd, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    $display("test reserved and unmapped done");

    apb(1'b1, PGC_ADDR_MASK, 32'h0000_0002);
    for (int k = 0; k < 7; k++) begin
      pin_case(k);
    end
    $display("test pin clear done");

    apb(1'b1, PGC_ADDR_CMD, 32'h0000_0004);
    apb(1'b0, PGC_ADDR_CMD, 32'h0);
    chk("main enable read", {31'h0, rd[PGC_BIT_MAIN_EN]}, 32'h1);
    chk("capture on", {31'h0, timestamp_capture_on}, 32'h1);
    apb(1'b1, PGC_ADDR_CMD, 32'h0);
    apb(1'b0, PGC_ADDR_CMD, 32'h0);
    chk("zero write ignored", {31'h0, rd[PGC_BIT_MAIN_EN]}, 32'h1);
    @(posedge clk_sys) main_disable <= 1'b1;
    @(posedge clk_sys) main_disable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("main disabled", {31'h0, ptp_enable}, 32'h0);
    chk("capture follows main", {31'h0, timestamp_capture_on}, 32'h0);
    // capture bit only changed while the unit is off
    apb(1'b1, PGC_ADDR_SETUP, 32'h0);
    apb(1'b1, PGC_ADDR_CMD, 32'h0000_0004);
    repeat (3) @(posedge clk_sys);
    chk("main on again", {31'h0, ptp_enable}, 32'h1);
    chk("capture off", {31'h0, timestamp_capture_on}, 32'h0);
    $display("test main enable done");
    tally_and_finish();
  end
endmodule : test_pgc_top
`default_nettype wire
